// [hw/dflm_monitor.sv]
// Fault behaviour, lock, contactor and brake supervision of the drive.
// Assumes error_i, sto_fault_i, drive_on_i, brake_open_cmd_i, run_end_i come
// from core_clk logic; contact and key pins are asynchronous.
`timescale 1ns/100ps
module dflm_monitor #(
  parameter int DROP_CYC = dflm_pkg::DROP_CYC,
  parameter int CDLY_CYC = dflm_pkg::CDLY_CYC,
  parameter int BRK_CYC  = dflm_pkg::BRK_CYC
) (
  input  wire logic       core_clk_i,
  input  wire logic       arst_n_i,
  input  wire logic [1:0] fault_behaviour_mode_i,
  input  wire logic       torque_off_supervision_i,
  input  wire logic       brake_lock_en_i,
  input  wire logic       brake_unlock_en_i,
  input  wire logic [4:0] terminal_io_configuration_i,
  input  wire logic [1:0] contactor_monitor_mode_i,
  input  wire logic [3:0] brake_monitor_config_i,
  input  wire logic       error_i,
  input  wire logic       sto_fault_i,
  input  wire logic       run_end_i,
  input  wire logic       drive_on_i,
  input  wire logic       brake_open_cmd_i,
  input  wire logic       contactor_feedback_a_i,
  input  wire logic       contactor_feedback_b_i,
  input  wire logic [3:0] brake_feedback_i,
  input  wire logic       ack_key_i,
  output logic            fault_output_o,
  output logic            lock_o,
  output logic            travel_inhibit_o,
  output logic [1:0]      fault_count_o,
  output logic            contactor_error_o,
  output logic            brake_error_o,
  output logic            lock_mark_o,
  output logic [1:0]      lock_mark_n_o
);

  localparam int W = dflm_pkg::CNT_W;
  localparam logic [W-1:0] DROP_V = DROP_CYC[W-1:0];
  localparam logic [W-1:0] CDLY_V = CDLY_CYC[W-1:0];
  localparam logic [W-1:0] BRK_V  = BRK_CYC[W-1:0];

  // Counts must fit the timers; dropout at least one cycle, contactor and brake windows at least two
  if (DROP_CYC < 1 || DROP_CYC >= 2**W || CDLY_CYC < 2 || CDLY_CYC >= 2**W
      || BRK_CYC < 2 || BRK_CYC >= 2**W)
  begin : g_chk
    $error("dflm_monitor: timing count out of range");
  end

  // ****************************************
  // Pin synchronisation
  // ****************************************
  logic [6:0] pin_s;
  logic       ack_prev_q;
  logic       ack_rise;

  dflm_sync #(
    .WIDTH (7)
  ) u_sync (
    .core_clk_i (core_clk_i),
    .arst_n_i   (arst_n_i),
    .d_i        ({ack_key_i, brake_feedback_i, contactor_feedback_b_i, contactor_feedback_a_i}),
    .q_o        (pin_s)
  );

  // Key edge: one press unlocks once, however long it is held
  always_ff @(posedge core_clk_i or negedge arst_n_i)
  begin
    if (!arst_n_i)
      ack_prev_q <= 1'b0;
    else
      ack_prev_q <= pin_s[6];
  end
  assign ack_rise = pin_s[6] & ~ack_prev_q;

  // ****************************************
  // Contactor monitor
  // ****************************************
  logic         drv_prev_q;
  logic         con_pend_q;
  logic         con_want_q;
  logic [W-1:0] con_cnt_q;
  logic         con_err_q;
  logic         con_ok;
  logic         con_closed;
  logic         con_open;

  // Single mode sees the series chain on input a only
  always_comb
  begin
    if (contactor_monitor_mode_i == dflm_pkg::CM_DUAL)
    begin
      con_closed = pin_s[0] & pin_s[1];
      con_open   = ~pin_s[0] & ~pin_s[1];
    end
    else
    begin
      con_closed = pin_s[0];
      con_open   = ~pin_s[0];
    end
    con_ok = con_want_q ? con_closed : con_open;
  end

  // Window opens on each start and stop edge of the drive command
  always_ff @(posedge core_clk_i or negedge arst_n_i)
  begin
    if (!arst_n_i)
    begin
      drv_prev_q <= 1'b0;
      con_pend_q <= 1'b0;
      con_want_q <= 1'b0;
      con_cnt_q  <= '0;
      con_err_q  <= 1'b0;
    end
    else
    begin
      drv_prev_q <= drive_on_i;
      con_err_q  <= 1'b0;
      if (drive_on_i != drv_prev_q && contactor_monitor_mode_i != dflm_pkg::CM_OFF)
      begin
        con_pend_q <= 1'b1;
        con_want_q <= drive_on_i;
        con_cnt_q  <= '0;
      end
      else if (con_pend_q)
      begin
        if (con_ok || contactor_monitor_mode_i == dflm_pkg::CM_OFF)
          con_pend_q <= 1'b0;
        else if (con_cnt_q == CDLY_V - 1'b1)
        begin
          con_pend_q <= 1'b0;
          con_err_q  <= 1'b1;
        end
        else
          con_cnt_q <= con_cnt_q + 1'b1;
      end
    end
  end

  // ****************************************
  // Brake monitor
  // ****************************************
  logic [3:0]   brk_mis;
  logic         brk_exp;
  logic         brk_bad;
  logic [W-1:0] brk_cnt_q;
  logic         brk_err_q;

  // NC contact reads closed when unpowered, NO reads open
  assign brk_exp = brake_monitor_config_i[dflm_pkg::BRK_NO_BIT] ? brake_open_cmd_i
                                                                 : ~brake_open_cmd_i;

  // Only the configured number of contacts is checked; count 0 checks none
  for (genvar i = 0; i < dflm_pkg::BRK_MAX; i++)
  begin : g_brk
    assign brk_mis[i] = (brake_monitor_config_i[2:0] > 3'(i)) & (pin_s[2+i] != brk_exp);
  end
  assign brk_bad = |brk_mis;

  // Mismatch must persist for the window before it counts as a malfunction
  always_ff @(posedge core_clk_i or negedge arst_n_i)
  begin
    if (!arst_n_i)
    begin
      brk_cnt_q <= '0;
      brk_err_q <= 1'b0;
    end
    else
    begin
      brk_err_q <= brk_bad && brk_cnt_q == BRK_V - 1'b1;
      if (!brk_bad)
        brk_cnt_q <= '0;
      else if (brk_cnt_q != BRK_V)
        brk_cnt_q <= brk_cnt_q + 1'b1;
    end
  end

  // ****************************************
  // Fault counting and lock
  // ****************************************
  logic         sto_err;
  logic         err_ev;
  logic [1:0]   cnt_q;
  logic [1:0]   cnt_nxt;
  logic [1:0]   need;
  logic         hit;
  logic         brk_lock_en;
  logic         lock_go;
  logic         lock_q;
  logic         lock_brk_q;
  logic         brk_release;
  logic         err_run_q;
  logic [W-1:0] drop_q;

  assign sto_err     = torque_off_supervision_i & sto_fault_i;
  assign err_ev      = error_i | sto_err | con_err_q | brk_err_q;
  assign cnt_nxt     = (cnt_q == 2'h3) ? cnt_q : cnt_q + 1'b1;
  assign need        = 2'h3 - (fault_behaviour_mode_i - 2'h1);
  assign hit         = fault_behaviour_mode_i != dflm_pkg::FB_FIX2 && cnt_nxt >= need;
  assign brk_lock_en = brake_lock_en_i | (terminal_io_configuration_i == dflm_pkg::TERM_LOCK_SEL);
  assign lock_go     = err_ev & (hit | (brk_err_q & brk_lock_en));
  assign brk_release = lock_brk_q & brake_unlock_en_i & ~brk_bad;

  // Counter: a new error wins over the clear of an error-free run end
  always_ff @(posedge core_clk_i or negedge arst_n_i)
  begin
    if (!arst_n_i)
    begin
      cnt_q     <= 2'h0;
      err_run_q <= 1'b0;
    end
    else
    begin
      if (err_ev && !lock_q)
        cnt_q <= cnt_nxt;
      else if ((run_end_i && !err_run_q) || (lock_q && (ack_rise || brk_release)))
        cnt_q <= 2'h0;
      if (err_ev)
        err_run_q <= 1'b1;
      else if (run_end_i)
        err_run_q <= 1'b0;
    end
  end

  // Lock: entry only while unlocked; an error in the release cycle is not counted
  always_ff @(posedge core_clk_i or negedge arst_n_i)
  begin
    if (!arst_n_i)
    begin
      lock_q        <= 1'b0;
      lock_brk_q    <= 1'b0;
      lock_mark_o   <= 1'b0;
      lock_mark_n_o <= 2'h0;
    end
    else
    begin
      lock_mark_o <= 1'b0;
      if (lock_go && !lock_q)
      begin
        lock_q        <= 1'b1;
        lock_brk_q    <= brk_err_q & brk_lock_en & ~hit;
        lock_mark_o   <= 1'b1;
        lock_mark_n_o <= hit ? need : 2'h1;
      end
      else if (lock_q && (ack_rise || brk_release))
      begin
        lock_q     <= 1'b0;
        lock_brk_q <= 1'b0;
      end
    end
  end

  // Dropout timer restarts on every error that neither finds nor enters a lock
  always_ff @(posedge core_clk_i or negedge arst_n_i)
  begin
    if (!arst_n_i)
      drop_q <= '0;
    else if (err_ev && !lock_go && !lock_q)
      drop_q <= DROP_V;
    else if (drop_q != '0)
      drop_q <= drop_q - 1'b1;
  end

  // ****************************************
  // Outputs
  // ****************************************
  // All outputs registered so the relay drivers see no glitches
  always_ff @(posedge core_clk_i or negedge arst_n_i)
  begin
    if (!arst_n_i)
    begin
      fault_output_o    <= dflm_pkg::FAULT_RST;
      lock_o            <= 1'b0;
      travel_inhibit_o  <= 1'b0;
      fault_count_o     <= 2'h0;
      contactor_error_o <= 1'b0;
      brake_error_o     <= 1'b0;
    end
    else
    begin
      fault_output_o    <= ~lock_q & (drop_q == '0);
      lock_o            <= lock_q;
      travel_inhibit_o  <= lock_q;
      fault_count_o     <= cnt_q;
      contactor_error_o <= con_err_q;
      brake_error_o     <= brk_err_q;
    end
  end

  // ****************************************
  // Assertions
  // ****************************************
  default clocking cb @(posedge core_clk_i); endclocking
  default disable iff (!arst_n_i);

  sequence s_err_free;
    err_ev && !lock_go && !lock_q;
  endsequence

  sequence s_out_dropped;
    drop_q == DROP_V ##1 !fault_output_o;
  endsequence

  a_drop_start: assert property (s_err_free |=> s_out_dropped)
    else $error("dropout did not start");
  a_drop_end: assert property (drop_q == 1 && !lock_q && !err_ev |=> ##1 fault_output_o)
    else $error("fault output not restored");
  a_lock_one: assert property (err_ev && !lock_q && fault_behaviour_mode_i == dflm_pkg::FB_LOCK1
                               |=> lock_q ##1 !fault_output_o)
    else $error("single error did not lock");
  a_fix_nolock: assert property (err_ev && !lock_q && !brk_err_q
                                 && fault_behaviour_mode_i == dflm_pkg::FB_FIX2 |=> !lock_q)
    else $error("default mode locked");
  a_cnt_clear: assert property (run_end_i && !err_run_q && !err_ev && !lock_q |=> cnt_q == 0)
    else $error("counter not cleared");
  a_ack_unlock: assert property (lock_q && ack_rise && !lock_go |=> !lock_q ##1 !lock_o)
    else $error("acknowledge did not unlock");
  a_lock_hold: assert property (lock_q && !ack_rise && !brk_release |=> lock_q ##1 travel_inhibit_o)
    else $error("lock lost without release");
  a_lock_mark: assert property (lock_go && !lock_q |=> lock_mark_o)
    else $error("lock entries not marked");
  a_sto_gate: assert property (sto_fault_i && torque_off_supervision_i && !lock_q && !lock_go
                               |=> drop_q == DROP_V)
    else $error("torque-off fault ignored");
  a_brk_auto: assert property (brk_err_q && !lock_q
                               && terminal_io_configuration_i == dflm_pkg::TERM_LOCK_SEL |=> lock_q)
    else $error("selection 31 did not lock on brake fault");
  a_brk_off: assert property (brake_monitor_config_i[2:0] == 3'h0 [*2] |-> !brk_err_q)
    else $error("brake checked while off");
  a_con_late: assert property (con_pend_q && !con_ok && con_cnt_q == CDLY_V - 1
                               && contactor_monitor_mode_i != dflm_pkg::CM_OFF
                               && drive_on_i == drv_prev_q |=> con_err_q ##1 contactor_error_o)
    else $error("contactor timeout missed");

endmodule

// [inc/dflm_pkg.sv]
// Constants shared by the drive fault lock monitor.
// Assumes a single 10 MHz core clock; times are converted to cycles here.
// Function
// - Default mode drops the fault output two seconds per malfunction, then restores it.
// - Blocking modes lock after three, two or one malfunctions; output stays dropped.
// - Successive-fault counter clears to zero after an error-free run.
// - While locked, show the lock; an operator acknowledge key returns normal operation.
// - Errors that led to the lock are flagged in the error list.
// - Torque-off supervision can be enabled or disabled; enabled by default.
// - Brake-fault lock setting on makes a brake malfunction lock the device.
// - Terminal configuration selection 31 forces the brake-fault lock setting on.
// - Brake-lock release setting on lifts a lock caused by a brake malfunction, unless that malfunction also completed a blocking mode's count.
// - Contactor monitor is off, single series input, or dual individual inputs.
// - Brake monitor accepts one to four normally-closed contacts, closed when unpowered.
// - Brake monitor accepts one to four normally-open contacts, open when unpowered.
// - Brake monitor off means no brake feedback checking at all.
// - Contactor feedback must confirm close at start and open at stop in time.
package dflm_pkg;

  // ****************************************
  // Clock and timing
  // ****************************************
  localparam int CLK_HZ      = 10_000_000;
  localparam int DROP_MS     = 2000;  // Fault output dropout time
  localparam int CDLY_MS     = 1500;  // Contactor reply window
  localparam int BRK_MS      = 400;   // Brake mismatch tolerance
  localparam int DROP_CYC    = DROP_MS * (CLK_HZ / 1000);
  localparam int CDLY_CYC    = CDLY_MS * (CLK_HZ / 1000);
  localparam int BRK_CYC     = BRK_MS * (CLK_HZ / 1000);
  localparam int CNT_W       = 25;    // Timer width, holds all three counts

  // ****************************************
  // Configuration encodings
  // ****************************************
  typedef enum logic [1:0] {
    FB_FIX2  = 2'h0,
    FB_LOCK3 = 2'h1,
    FB_LOCK2 = 2'h2,
    FB_LOCK1 = 2'h3
  } dflm_fault_mode_e;

  typedef enum logic [1:0] {
    CM_OFF    = 2'h0,
    CM_SINGLE = 2'h1,
    CM_DUAL   = 2'h2
  } dflm_con_mode_e;

  localparam int       BRK_NO_BIT    = 3;     // Config bit 3: 1 = normally open
  localparam int       BRK_MAX       = 4;     // Config bits 2:0: contact count
  localparam logic [4:0] TERM_LOCK_SEL = 5'h1f; // Selection 31
  localparam logic     FAULT_RST     = 1'b0;  // Output dropped during reset

endpackage

// [hw/dflm_sync.sv]
// Two-stage synchroniser for the contact and key pins.
// Assumes the pins are slow levels; only the second stage is read outside.
`timescale 1ns/100ps
module dflm_sync #(
  parameter int WIDTH = 1
) (
  input  wire logic             core_clk_i,
  input  wire logic             arst_n_i,
  input  wire logic [WIDTH-1:0] d_i,
  output logic      [WIDTH-1:0] q_o
);

  logic [WIDTH-1:0] meta_q;

  // One bit at least, or there is nothing to carry
  if (WIDTH < 1)
  begin : g_chk
    $error("dflm_sync: WIDTH must be at least 1");
  end

  // ****************************************
  // Sync stages
  // ****************************************
  // First stage feeds only the second stage
  always_ff @(posedge core_clk_i or negedge arst_n_i)
  begin
    if (!arst_n_i)
    begin
      meta_q <= '0;
      q_o    <= '0;
    end
    else
    begin
      meta_q <= d_i;
      q_o    <= meta_q;
    end
  end

endmodule

// [sim/dflm_plant.sv]
// Plant model: motor contactors and brake feedback contacts.
// Assumes commands come from core_clk logic; contactors answer 3 or 40 cycles late, brake contacts at once.
`timescale 1ns/100ps
module dflm_plant (
  input  wire logic       core_clk_i,
  input  wire logic       drive_on_i,
  input  wire logic       brake_open_cmd_i,
  input  wire logic       brake_no_i,
  input  wire logic [1:0] con_slow_i,
  input  wire logic [3:0] brake_stuck_i,
  output logic            contactor_feedback_a_o,
  output logic            contactor_feedback_b_o,
  output logic [3:0]      brake_feedback_o
);
  // ****
  // Contactors
  // ****
  logic        drv_q = 1'b0;
  int unsigned age_q = 0;
  // Cycles since the last command change; a slow contact needs 40, past a short window
  always @(posedge core_clk_i)
  begin
    drv_q <= drive_on_i;
    age_q <= (drv_q != drive_on_i) ? 0 : age_q + 1;
  end
  // Until it moves, a contact still shows the old state
  assign contactor_feedback_a_o = (age_q >= (con_slow_i[0] ? 40 : 3)) ? drv_q : !drv_q;
  assign contactor_feedback_b_o = (age_q >= (con_slow_i[1] ? 40 : 3)) ? drv_q : !drv_q;
  // ****
  // Brake contacts
  // ****
  // Opener closed when unpowered, closer closed when powered; stuck ones read inverted
  assign brake_feedback_o = {4{brake_no_i ? brake_open_cmd_i : !brake_open_cmd_i}} ^ brake_stuck_i;
endmodule

// [sim/tb_drive_fault_lock_monitor.sv]
// Self-checking bench of the fault lock monitor with the plant model.
// Assumes short timer parameters; every wait is a fixed bounded count.
`timescale 1ns/100ps
module tb_drive_fault_lock_monitor;
  localparam int DROP = 20;
  localparam int CDLY = 16;
  localparam int BRK  = 8;
`define CHK(nm, ex, sn) \
  begin samples_checked++; if ((sn) !== (ex)) begin mismatches++; \
  $display("mismatch %s expected %0h seen %0h", nm, ex, sn); end end
  logic       core_clk_i = 1'b0;
  logic       arst_n_i = 1'b0;
  logic [3:0] pul = 4'h0;  // Error, torque-off fault, run end, ack key
  logic [1:0] fmode = 2'h0, cmode = 2'h0, con_slow = 2'h0, fcnt, lmark_n;
  logic       sto_sup = 1'b1, blk_en = 1'b0, bunl_en = 1'b0, drive_on = 1'b0;
  logic       brk_cmd = 1'b0, brk_no = 1'b0, fb_a, fb_b, fout, lock, inhib, cerr, berr, lmark;
  logic [4:0] term = 5'h00;
  logic [3:0] bcfg = 4'h0, stuck = 4'h0, brk_fb;
  logic [4:0] ctab [6] = '{5'h06, 5'h08, 5'h0c, 5'h15, 5'h0b, 5'h1c};
  logic [9:0] btab [7] = '{10'h040, 10'h050, 10'h111, 10'h002, 10'h260, 10'h241, 10'h331};
  int         mismatches = 0, samples_checked = 0, marks = 0, cerrs = 0, berrs = 0, n0;

  dflm_monitor #(.DROP_CYC(DROP), .CDLY_CYC(CDLY), .BRK_CYC(BRK)) dut_u (
    .core_clk_i                 (core_clk_i),
    .arst_n_i                   (arst_n_i),
    .fault_behaviour_mode_i     (fmode),
    .torque_off_supervision_i   (sto_sup),
    .brake_lock_en_i            (blk_en),
    .brake_unlock_en_i          (bunl_en),
    .terminal_io_configuration_i(term),
    .contactor_monitor_mode_i   (cmode),
    .brake_monitor_config_i     (bcfg),
    .error_i                    (pul[0]),
    .sto_fault_i                (pul[1]),
    .run_end_i                  (pul[2]),
    .drive_on_i                 (drive_on),
    .brake_open_cmd_i           (brk_cmd),
    .contactor_feedback_a_i     (fb_a),
    .contactor_feedback_b_i     (fb_b),
    .brake_feedback_i           (brk_fb),
    .ack_key_i                  (pul[3]),
    .fault_output_o             (fout),
    .lock_o                     (lock),
    .travel_inhibit_o           (inhib),
    .fault_count_o              (fcnt),
    .contactor_error_o          (cerr),
    .brake_error_o              (berr),
    .lock_mark_o                (lmark),
    .lock_mark_n_o              (lmark_n)
  );
  dflm_plant plant_u (
    .core_clk_i            (core_clk_i),
    .drive_on_i            (drive_on),
    .brake_open_cmd_i      (brk_cmd),
    .brake_no_i            (brk_no),
    .con_slow_i            (con_slow),
    .brake_stuck_i         (stuck),
    .contactor_feedback_a_o(fb_a),
    .contactor_feedback_b_o(fb_b),
    .brake_feedback_o      (brk_fb)
  );
  // ****
  // Clock, pulse counters, watchdog
  // ****
  initial
  begin
    forever #50 core_clk_i = ~core_clk_i;
  end
  // One-cycle pulses are counted so no check has to hit their exact edge
  always @(posedge core_clk_i)
  begin
    if (lmark === 1'b1) marks++;
    if (cerr === 1'b1) cerrs++;
    if (berr === 1'b1) berrs++;
  end
  initial
  begin
    repeat (20000) @(posedge core_clk_i);
    mismatches++;
    give_verdict();
  end
  task automatic tick(input int n);
    repeat (n) @(posedge core_clk_i);
    #1;
  endtask
  // Holds one strobe high for n cycles; each high cycle is one event, but the ack key counts once per press
  task automatic hit(input int b, input int n);
    if (n > 0)
    begin
      @(posedge core_clk_i);
      pul[b] <= 1'b1;
      repeat (n) @(posedge core_clk_i);
      pul[b] <= 1'b0;
    end
  endtask
  task automatic give_verdict();
    $display("checked %0d mismatches %0d", samples_checked, mismatches);
    if (mismatches == 0 && samples_checked > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask
  // ****
  // Scenarios
  // ****
  initial
  begin
    repeat (3) @(posedge core_clk_i);
    `CHK("fault out", 1'b0, fout)
    arst_n_i <= 1'b1;
    tick(2);
    `CHK("fault out", 1'b1, fout)
    hit(0, 1);
    tick(3);
    `CHK("fault out", 1'b0, fout)
    `CHK("count", 2'h1, fcnt)
    tick(DROP - 3);
    `CHK("fault out", 1'b0, fout)
    tick(1);
    `CHK("fault out", 1'b1, fout)
    `CHK("lock", 1'b0, lock)
    // The run that held the error is not error-free, so only the next run end clears
    hit(2, 1);
    tick(3);
    `CHK("count", 2'h1, fcnt)
    hit(2, 1);
    tick(3);
    `CHK("count", 2'h0, fcnt)
    // Lock after three, two, one errors; one short must not lock
    for (int m = 1; m < 4; m++)
    begin
      @(posedge core_clk_i);
      fmode <= m[1:0];
      hit(2, 1);
      hit(0, 3 - m);
      tick(3);
      `CHK("lock", 1'b0, lock)
      hit(0, 1);
      tick(3);
      `CHK("lock", 1'b1, lock)
      `CHK("inhibit", 1'b1, inhib)
      `CHK("marked", 2'(4 - m), lmark_n)
      hit(0, 2);
      tick(DROP + 4);
      `CHK("fault out", 1'b0, fout)
      `CHK("count", 2'(4 - m), fcnt)
      hit(3, 6);
      tick(3);
      `CHK("lock", 1'b0, lock)
      `CHK("fault out", 1'b1, fout)
      `CHK("count", 2'h0, fcnt)
    end
    `CHK("marks", 3, marks)
    @(posedge core_clk_i);
    fmode <= 2'h0;
    sto_sup <= 1'b0;
    hit(1, 1);
    tick(3);
    `CHK("fault out", 1'b1, fout)
    @(posedge core_clk_i);
    sto_sup <= 1'b1;
    hit(1, 1);
    tick(3);
    `CHK("fault out", 1'b0, fout)
    // Contactor modes against prompt and slow contacts, start and stop alternating
    foreach (ctab[i])
    begin
      @(posedge core_clk_i);
      {cmode, con_slow} <= ctab[i][4:1];
      n0 = cerrs;
      @(posedge core_clk_i);
      drive_on <= !drive_on;
      tick(50);
      `CHK("contactor err", ctab[i][0], cerrs - n0)
    end
    // Brake counts and polarities; a clean gap ends each mismatch episode
    foreach (btab[i])
    begin
      @(posedge core_clk_i);
      {bcfg, brk_no, stuck} <= btab[i][9:1];
      brk_cmd <= !brk_cmd;
      n0 = berrs;
      tick(BRK + 6);
      `CHK("brake err", btab[i][0], berrs - n0)
      @(posedge core_clk_i);
      brk_no <= bcfg[3];
      stuck <= 4'h0;
      tick(4);
    end
    `CHK("lock", 1'b0, lock)
    @(posedge core_clk_i);
    {bcfg, brk_no, blk_en, stuck} <= {4'h1, 1'b0, 1'b1, 4'h1};
    tick(BRK + 6);
    `CHK("lock", 1'b1, lock)
    `CHK("marked", 2'h1, lmark_n)
    @(posedge core_clk_i);
    {bunl_en, stuck} <= {1'b1, 4'h0};
    tick(6);
    `CHK("lock", 1'b0, lock)
    @(posedge core_clk_i);
    {blk_en, bunl_en, term, stuck} <= {2'b00, 5'h1f, 4'h1};
    tick(BRK + 6);
    `CHK("lock", 1'b1, lock)
    @(posedge core_clk_i);
    stuck <= 4'h0;
    tick(6);
    `CHK("lock", 1'b1, lock)
    hit(3, 6);
    tick(DROP + 4);
    `CHK("lock", 1'b0, lock)
    `CHK("fault out", 1'b1, fout)
    give_verdict();
  end
endmodule
